/* hw/sfic_regs.svh */
// register offsets, field positions, reset values and counts
`ifndef SFIC_REGS_SVH
`define SFIC_REGS_SVH
`define SFIC_ADDR_MUX_CFG    8'hAF
`define SFIC_ADDR_SYSINT_EN  8'hB2
`define SFIC_ADDR_SPECTRAL_PERSISTENCE       8'hBD
`define SFIC_ADDR_LEVEL      8'hFD
`define SFIC_ADDR_BUF_LOW    8'hFE
`define SFIC_ADDR_BUF_HIGH   8'hFF
`define SFIC_MUX_CMD_MSB     4
`define SFIC_MUX_CMD_LSB     3
`define SFIC_MUX_CMD_RESET   2'h2
`define SFIC_MUX_CMD_RSVD    2'h3
`define SFIC_FLICKER_EN_BIT  6
`define SFIC_MUX_DONE_EN_BIT 4
`define SFIC_SPECTRAL_PERSISTENCE_MSB        3
`define SFIC_SPECTRAL_PERSISTENCE_RESET      4'h0
`define SFIC_SPECTRAL_PERSISTENCE_LINEAR_MAX 4'h3
`define SFIC_SPECTRAL_PERSISTENCE_FOUR       4'h4
`define SFIC_SPECTRAL_PERSISTENCE_FOUR_REQ   6'h05
`define SFIC_SPECTRAL_PERSISTENCE_STEP       6'h05
`define SFIC_SPECTRAL_PERSISTENCE_OFFSET     6'h03
`define SFIC_SPECTRAL_PERSISTENCE_CNT_MAX    6'h3F
`define SFIC_BUF_FULL        8'h80
`define SFIC_I2C_BITS        4'h8
`endif

/* hw/sfic_pkg.sv */
// types shared by the buffer and interrupt configuration block
`default_nettype none
package sfic_pkg;
   typedef enum logic [8:0] {
      st_idle      = 9'h001,
      st_addr      = 9'h002,
      st_addr_ack  = 9'h004,
      st_reg       = 9'h008,
      st_reg_ack   = 9'h010,
      st_wdata     = 9'h020,
      st_wdata_ack = 9'h040,
      st_rdata     = 9'h080,
      st_rdata_ack = 9'h100
   } sfic_i2c_state_t;

   typedef enum logic [1:0] {
      mux_rom_init  = 2'h0,
      mux_read_ram  = 2'h1,
      mux_write_ram = 2'h2,
      mux_reserved  = 2'h3
   } sfic_mux_cmd_t;

   typedef struct packed {
      logic        valid;
      logic [2:0]  channel;
      logic [15:0] value;
   } sfic_sample_t;

   typedef struct packed {
      logic [15:0] low;
      logic [15:0] high;
   } sfic_threshold_t;

   typedef struct packed {
      logic        valid;
      logic [15:0] data;
   } sfic_entry_t;
endpackage : sfic_pkg
`default_nettype wire

/* hw/sfic_sync.sv */
// two-flop synchroniser for one external level
`default_nettype none
module sfic_sync #(
   parameter logic RESET_LEVEL = 1'b1
) (
   input  wire logic sys_clk,
   input  wire logic rst_n,
   input  wire logic async_in,
   output logic      sync_out
);
   logic meta;

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         meta     <= RESET_LEVEL;
         sync_out <= RESET_LEVEL;
      end else begin
         meta     <= async_in;
         sync_out <= meta;
      end
   end
endmodule : sfic_sync
`default_nettype wire

/* hw/sfic_top.sv */
// readout buffer, mux command, system interrupt and persistence logic behind i2c
// Functional notes
// - rising measurement enable starts the mux command held in config bits 4:3 unless it is 3.
// - command 0 rom init, 1 chain to ram, 2 ram to chain, 3 reserved.
// - mux command field resets to 2.
// - flicker enable bit 6 gives a system interrupt on each flicker status change.
// - mux done enable bit 4 gives a system interrupt when a mux command completes.
// - count consecutive out-of-range samples of selected channel; interrupt when count met.
// - an in-range sample of the selected channel clears the count.
// - persistence 0 every selected-channel sample, 1-3 as is, 4 gives 5, else 5*(v-3).
// - buffer holds 128 entries of two bytes, 256 bytes total.
// - an entry arriving while full sets overflow and is dropped.
// - read address pointer wraps from 0xFF back to 0xFE.
// - single byte and unlimited burst reads of buffer data are accepted.
// - each read of 0xFF while the level is nonzero advances the read pointer and lowers the level.
// - bursts advance pointer and level once per two-byte entry.
// - buffer reads with level zero return zero.
// - buffer data interrupt is high while unread entries exist.
// - level count tracks unread entries on writes and reads.
// - level is an eight-bit read-only count from 0 to 128.
`include "sfic_regs.svh"
`default_nettype none
module sfic_top #(
   parameter logic [6:0] DEV_ADDR = 7'h2A,
   parameter int         ENTRIES  = 128,
   parameter int         PTR_W    = 7
) (
   input  wire logic                     sys_clk,
   input  wire logic                     rst_n,
   input  wire logic                     scl_in,
   input  wire logic                     sda_in,
   output logic                          sda_out,
   output logic                          sda_oe,
   input  wire logic                     measurement_enable,
   input  wire logic                     mux_command_done,
   input  wire logic                     flicker_status,
   input  wire sfic_pkg::sfic_sample_t    spectral_sample,
   input  wire sfic_pkg::sfic_threshold_t spectral_threshold,
   input  wire logic [2:0]               threshold_channel_select,
   input  wire sfic_pkg::sfic_entry_t     buffer_entry,
   output logic                          mux_command_start,
   output sfic_pkg::sfic_mux_cmd_t        mux_command_code,
   output logic                          system_interrupt,
   output logic                          spectral_interrupt,
   output logic                          buffer_data_interrupt,
   output logic                          buffer_overflow,
   output logic [7:0]                    buffer_level_count
);
   logic                     scl_s, sda_s, scl_prev, sda_prev;
   logic                     scl_rise, scl_fall, start_seen, stop_seen;
   sfic_pkg::sfic_i2c_state_t state;
   logic [3:0]               bit_cnt;
   logic [7:0]               shift, reg_ptr, next_reg_ptr, wr_addr, wr_data, rd_byte;
   logic                     rw, host_ack, load_now, reg_wr, pop_req, level_read;
   logic [1:0]               mux_command_select;
   logic                     flicker_sysint_enable, mux_done_sysint_enable;
   logic [3:0]               spectral_persistence_count;
   logic [15:0]              mem [ENTRIES];
   logic [PTR_W-1:0]         wr_ptr, rd_ptr;
   logic                     push, meas_prev, flicker_prev, sample_hit, sample_out;
   logic [7:0]               next_level;
   logic [5:0]               spectral_persistence_cnt, spectral_persistence_req, next_spectral_persistence_cnt;

   // pin synchronisers
   sfic_sync #(.RESET_LEVEL(1'b1)) u_scl_sync (
      .sys_clk  (sys_clk),
      .rst_n    (rst_n),
      .async_in (scl_in),
      .sync_out (scl_s)
   );
   sfic_sync #(.RESET_LEVEL(1'b1)) u_sda_sync (
      .sys_clk  (sys_clk),
      .rst_n    (rst_n),
      .async_in (sda_in),
      .sync_out (sda_s)
   );

   assign scl_rise   = scl_s & ~scl_prev;
   assign scl_fall   = ~scl_s & scl_prev;
   assign start_seen = scl_s & scl_prev & sda_prev & ~sda_s;
   assign stop_seen  = scl_s & scl_prev & ~sda_prev & sda_s;

   // pointer wraps inside the data pair
   assign next_reg_ptr = (reg_ptr == `SFIC_ADDR_BUF_HIGH) ? `SFIC_ADDR_BUF_LOW
                                                          : reg_ptr + 8'h01;
   assign load_now = scl_fall &&
                     ((state == sfic_pkg::st_addr_ack && rw) ||
                      (state == sfic_pkg::st_rdata_ack && host_ack));

   // register read mux
   always_comb begin
      rd_byte = 8'h00;
      case (reg_ptr)
         `SFIC_ADDR_MUX_CFG:
            rd_byte[`SFIC_MUX_CMD_MSB:`SFIC_MUX_CMD_LSB] = mux_command_select;
         `SFIC_ADDR_SYSINT_EN: begin
            rd_byte[`SFIC_FLICKER_EN_BIT]  = flicker_sysint_enable;
            rd_byte[`SFIC_MUX_DONE_EN_BIT] = mux_done_sysint_enable;
         end
         `SFIC_ADDR_SPECTRAL_PERSISTENCE:
            rd_byte[`SFIC_SPECTRAL_PERSISTENCE_MSB:0] = spectral_persistence_count;
         `SFIC_ADDR_LEVEL:
            rd_byte = buffer_level_count;
         `SFIC_ADDR_BUF_LOW:
            if (buffer_level_count != 8'h00) rd_byte = mem[rd_ptr][7:0];
         `SFIC_ADDR_BUF_HIGH:
            if (buffer_level_count != 8'h00) rd_byte = mem[rd_ptr][15:8];
         default:
            rd_byte = 8'h00;
      endcase
   end

   // i2c target
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         state      <= sfic_pkg::st_idle;
         bit_cnt    <= 4'h0;
         shift      <= 8'h00;
         rw         <= 1'b0;
         host_ack   <= 1'b0;
         reg_ptr    <= 8'h00;
         sda_oe     <= 1'b0;
         reg_wr     <= 1'b0;
         wr_addr    <= 8'h00;
         wr_data    <= 8'h00;
         pop_req    <= 1'b0;
         level_read <= 1'b0;
         scl_prev   <= 1'b1;
         sda_prev   <= 1'b1;
         sda_out    <= 1'b0;
      end else begin
         scl_prev   <= scl_s;
         sda_prev   <= sda_s;
         sda_out    <= 1'b0;
         reg_wr     <= 1'b0;
         pop_req    <= 1'b0;
         level_read <= 1'b0;
         if (start_seen) begin
            state   <= sfic_pkg::st_addr;
            bit_cnt <= 4'h0;
            sda_oe  <= 1'b0;
         end else if (stop_seen) begin
            state  <= sfic_pkg::st_idle;
            sda_oe <= 1'b0;
         end else if (load_now) begin
            shift      <= rd_byte;
            sda_oe     <= ~rd_byte[7];
            bit_cnt    <= 4'h0;
            reg_ptr    <= next_reg_ptr;
            pop_req    <= (reg_ptr == `SFIC_ADDR_BUF_HIGH) &&
                          (buffer_level_count != 8'h00);
            level_read <= (reg_ptr == `SFIC_ADDR_LEVEL);
            state      <= sfic_pkg::st_rdata;
         end else if (scl_rise) begin
            case (state)
               sfic_pkg::st_addr, sfic_pkg::st_reg, sfic_pkg::st_wdata: begin
                  shift   <= {shift[6:0], sda_s};
                  bit_cnt <= bit_cnt + 4'h1;
               end
               sfic_pkg::st_rdata:     bit_cnt  <= bit_cnt + 4'h1;
               sfic_pkg::st_rdata_ack: host_ack <= ~sda_s;
               default: ;
            endcase
         end else if (scl_fall) begin
            case (state)
               sfic_pkg::st_addr:
                  if (bit_cnt == `SFIC_I2C_BITS) begin
                     if (shift[7:1] == DEV_ADDR) begin
                        rw     <= shift[0];
                        sda_oe <= 1'b1;
                        state  <= sfic_pkg::st_addr_ack;
                     end else begin
                        state <= sfic_pkg::st_idle;
                     end
                  end
               sfic_pkg::st_reg:
                  if (bit_cnt == `SFIC_I2C_BITS) begin
                     reg_ptr <= shift;
                     sda_oe  <= 1'b1;
                     state   <= sfic_pkg::st_reg_ack;
                  end
               sfic_pkg::st_wdata:
                  if (bit_cnt == `SFIC_I2C_BITS) begin
                     reg_wr  <= 1'b1;
                     wr_addr <= reg_ptr;
                     wr_data <= shift;
                     reg_ptr <= next_reg_ptr;
                     sda_oe  <= 1'b1;
                     state   <= sfic_pkg::st_wdata_ack;
                  end
               sfic_pkg::st_addr_ack: begin
                  sda_oe  <= 1'b0;
                  bit_cnt <= 4'h0;
                  state   <= sfic_pkg::st_reg;
               end
               sfic_pkg::st_reg_ack, sfic_pkg::st_wdata_ack: begin
                  sda_oe  <= 1'b0;
                  bit_cnt <= 4'h0;
                  state   <= sfic_pkg::st_wdata;
               end
               sfic_pkg::st_rdata:
                  if (bit_cnt == `SFIC_I2C_BITS) begin
                     sda_oe <= 1'b0;
                     state  <= sfic_pkg::st_rdata_ack;
                  end else begin
                     shift  <= {shift[6:0], 1'b0};
                     sda_oe <= ~shift[6];
                  end
               sfic_pkg::st_rdata_ack: begin
                  sda_oe <= 1'b0;
                  state  <= sfic_pkg::st_idle;
               end
               default: state <= sfic_pkg::st_idle;
            endcase
         end
      end
   end

   // configuration registers
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         mux_command_select         <= `SFIC_MUX_CMD_RESET;
         flicker_sysint_enable      <= 1'b0;
         mux_done_sysint_enable     <= 1'b0;
         spectral_persistence_count <= `SFIC_SPECTRAL_PERSISTENCE_RESET;
      end else if (reg_wr) begin
         case (wr_addr)
            `SFIC_ADDR_MUX_CFG:
               mux_command_select <= wr_data[`SFIC_MUX_CMD_MSB:`SFIC_MUX_CMD_LSB];
            `SFIC_ADDR_SYSINT_EN: begin
               flicker_sysint_enable  <= wr_data[`SFIC_FLICKER_EN_BIT];
               mux_done_sysint_enable <= wr_data[`SFIC_MUX_DONE_EN_BIT];
            end
            `SFIC_ADDR_SPECTRAL_PERSISTENCE:
               spectral_persistence_count <= wr_data[`SFIC_SPECTRAL_PERSISTENCE_MSB:0];
            default: ;
         endcase
      end
   end

   // mux command start and system interrupt
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         meas_prev         <= 1'b0;
         flicker_prev      <= 1'b0;
         mux_command_start <= 1'b0;
         mux_command_code  <= sfic_pkg::mux_write_ram;
         system_interrupt  <= 1'b0;
      end else begin
         meas_prev         <= measurement_enable;
         flicker_prev      <= flicker_status;
         mux_command_start <= measurement_enable && !meas_prev &&
                              (mux_command_select != `SFIC_MUX_CMD_RSVD);
         if (measurement_enable && !meas_prev)
            mux_command_code <= sfic_pkg::sfic_mux_cmd_t'(mux_command_select);
         system_interrupt  <= (flicker_sysint_enable && (flicker_status != flicker_prev)) ||
                              (mux_done_sysint_enable && mux_command_done);
      end
   end

   // persistence filter
   always_comb begin
      if (spectral_persistence_count <= `SFIC_SPECTRAL_PERSISTENCE_LINEAR_MAX)
         spectral_persistence_req = {2'b00, spectral_persistence_count};
      else if (spectral_persistence_count == `SFIC_SPECTRAL_PERSISTENCE_FOUR)
         spectral_persistence_req = `SFIC_SPECTRAL_PERSISTENCE_FOUR_REQ;
      else
         spectral_persistence_req = 6'(({2'b00, spectral_persistence_count} - `SFIC_SPECTRAL_PERSISTENCE_OFFSET) *
                       `SFIC_SPECTRAL_PERSISTENCE_STEP);
   end

   assign sample_hit    = spectral_sample.valid &&
                          (spectral_sample.channel == threshold_channel_select);
   assign sample_out    = (spectral_sample.value < spectral_threshold.low) ||
                          (spectral_sample.value > spectral_threshold.high);
   assign next_spectral_persistence_cnt = (spectral_persistence_cnt == `SFIC_SPECTRAL_PERSISTENCE_CNT_MAX) ? spectral_persistence_cnt : spectral_persistence_cnt + 6'h01;

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         spectral_persistence_cnt           <= 6'h00;
         spectral_interrupt <= 1'b0;
      end else begin
         spectral_interrupt <= 1'b0;
         if (sample_hit) begin
            if (sample_out) begin
               spectral_persistence_cnt           <= next_spectral_persistence_cnt;
               spectral_interrupt <= (next_spectral_persistence_cnt >= spectral_persistence_req);
            end else begin
               spectral_persistence_cnt <= 6'h00;
            end
            if (spectral_persistence_count == `SFIC_SPECTRAL_PERSISTENCE_RESET)
               spectral_interrupt <= 1'b1;
         end
      end
   end

   // readout buffer
   assign push = buffer_entry.valid && (buffer_level_count != `SFIC_BUF_FULL);

   always_comb begin
      case ({push, pop_req})
         2'b10:   next_level = buffer_level_count + 8'h01;
         2'b01:   next_level = buffer_level_count - 8'h01;
         default: next_level = buffer_level_count;
      endcase
   end

   always_ff @(posedge sys_clk) begin
      if (push) mem[wr_ptr] <= buffer_entry.data;
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         wr_ptr                <= '0;
         rd_ptr                <= '0;
         buffer_level_count    <= 8'h00;
         buffer_data_interrupt <= 1'b0;
         buffer_overflow       <= 1'b0;
      end else begin
         if (push) wr_ptr <= wr_ptr + PTR_W'(1);
         if (pop_req) rd_ptr <= rd_ptr + PTR_W'(1);
         buffer_level_count    <= next_level;
         buffer_data_interrupt <= (next_level != 8'h00);
         if (buffer_entry.valid && !push)
            buffer_overflow <= 1'b1;
         else if (level_read)
            buffer_overflow <= 1'b0;
      end
   end
endmodule : sfic_top
`default_nettype wire

/* verification/sfic_top_asserts.sv */
// checker bound to the buffer and interrupt configuration top
`default_nettype none
module sfic_top_asserts #(
   parameter logic [6:0] DEV_ADDR = 7'h2A,
   parameter int         ENTRIES  = 128,
   parameter int         PTR_W    = 7
) (
   input wire logic                     sys_clk,
   input wire logic                     rst_n,
   input wire logic                     scl_in,
   input wire logic                     sda_in,
   input wire logic                     sda_out,
   input wire logic                     sda_oe,
   input wire logic                     measurement_enable,
   input wire logic                     mux_command_done,
   input wire logic                     flicker_status,
   input wire sfic_pkg::sfic_sample_t    spectral_sample,
   input wire sfic_pkg::sfic_threshold_t spectral_threshold,
   input wire logic [2:0]               threshold_channel_select,
   input wire sfic_pkg::sfic_entry_t     buffer_entry,
   input wire logic                     mux_command_start,
   input wire sfic_pkg::sfic_mux_cmd_t   mux_command_code,
   input wire logic                     system_interrupt,
   input wire logic                     spectral_interrupt,
   input wire logic                     buffer_data_interrupt,
   input wire logic                     buffer_overflow,
   input wire logic [7:0]               buffer_level_count
);
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!rst_n);
   sequence full_push;
      buffer_entry.valid && int'(buffer_level_count) == ENTRIES;
   endsequence
   sequence empty_push;
      buffer_entry.valid && buffer_level_count == 8'h00;
   endsequence
   buf_irq_a: assert property ($stable(buffer_level_count) |->
      buffer_data_interrupt == (buffer_level_count != 8'h00)) else $error("buffer irq wrong");
   push_level_a: assert property (empty_push |=> buffer_level_count == 8'h01)
      else $error("push not counted");
   full_ovf_a: assert property (full_push |=> buffer_overflow)
      else $error("overflow not set");
   level_step_a: assert property (!$stable(buffer_level_count) |->
      buffer_level_count - $past(buffer_level_count) inside {8'h01, 8'hFF}) else $error("level jump");
   ovf_cause_a: assert property ($rose(buffer_overflow) |->
      $past(buffer_entry.valid) && $past(buffer_level_count) == 8'h80) else $error("stray overflow");
   mux_start_a: assert property (mux_command_start |->
      $past(measurement_enable) && !$past(measurement_enable, 2)) else $error("stray mux start");
   sysint_cause_a: assert property (system_interrupt |->
      $past(flicker_status) != $past(flicker_status, 2) || $past(mux_command_done))
      else $error("stray system interrupt");
   spec_cause_a: assert property (spectral_interrupt |->
      $past(spectral_sample.valid) &&
      $past(spectral_sample.channel) == $past(threshold_channel_select)) else $error("stray irq");
endmodule : sfic_top_asserts
bind sfic_top sfic_top_asserts #(.DEV_ADDR(DEV_ADDR), .ENTRIES(ENTRIES), .PTR_W(PTR_W))
   i_sfic_top_asserts (.sys_clk(sys_clk), .rst_n(rst_n), .scl_in(scl_in), .sda_in(sda_in),
   .sda_out(sda_out), .sda_oe(sda_oe), .measurement_enable(measurement_enable),
   .mux_command_done(mux_command_done), .flicker_status(flicker_status),
   .spectral_sample(spectral_sample), .spectral_threshold(spectral_threshold),
   .threshold_channel_select(threshold_channel_select), .buffer_entry(buffer_entry),
   .mux_command_start(mux_command_start), .mux_command_code(mux_command_code),
   .system_interrupt(system_interrupt), .spectral_interrupt(spectral_interrupt),
   .buffer_data_interrupt(buffer_data_interrupt), .buffer_overflow(buffer_overflow),
   .buffer_level_count(buffer_level_count));
`default_nettype wire

/* verification/sfic_i2c_host.sv */
// behavioural i2c bus controller on the serial pins
`default_nettype none
module sfic_i2c_host #(
   parameter logic [6:0] DEV_ADDR = 7'h2A
) (
   output logic      scl,
   output logic      host_oe,
   input  wire logic sda
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [7:0] rq[$];
   int         nack_count = 0;
   logic       b;
   initial begin
      scl = 1'b1;
      host_oe = 1'b0;
   end
   task automatic put_bit(input logic v);
      #200 host_oe = ~v;
      #200 scl = 1'b1;
      #400 scl = 1'b0;
   endtask : put_bit
   task automatic get_bit(output logic v);
      host_oe = 1'b0;
      #400 scl = 1'b1;
      #200 v = sda;
      #200 scl = 1'b0;
   endtask : get_bit
   task automatic start;
      #300 host_oe = 1'b0;
      #300 scl = 1'b1;
      #400 host_oe = 1'b1;
      #400 scl = 1'b0;
   endtask : start
   task automatic stop;
      #200 host_oe = 1'b1;
      #200 scl = 1'b1;
      #400 host_oe = 1'b0;
      #800;
   endtask : stop
   task automatic send(input logic [7:0] d);
      for (int i = 7; i >= 0; i--) put_bit(d[i]);
      get_bit(b);
      if (b) nack_count++;
   endtask : send
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      start;
      send({DEV_ADDR, 1'b0});
      send(a);
      send(d);
      stop;
   endtask : wr
   // pointer set, repeated start, bytes acked until the last
   task automatic rd(input logic [7:0] a, input int n);
      logic [7:0] v;
      start;
      send({DEV_ADDR, 1'b0});
      send(a);
      start;
      send({DEV_ADDR, 1'b1});
      for (int k = 0; k < n; k++) begin
         for (int i = 7; i >= 0; i--) get_bit(v[i]);
         rq.push_back(v);
         put_bit(k == n - 1);
      end
      stop;
   endtask : rd
endmodule : sfic_i2c_host
`default_nettype wire

/* verification/sfic_top_test.sv */
// self-checking bench for the buffer and interrupt configuration block
`default_nettype none
module sfic_top_test;
   timeunit 1ns;
   timeprecision 1ns;
   logic                      sys_clk = 1'b0;
   logic                      rst_n = 1'b0;
   logic                      meas = 1'b0;
   logic                      mdone = 1'b0;
   logic                      flick = 1'b0;
   logic                      scl, host_oe, sda, sda_out, sda_oe, start_o, sysint, spint, birq, ovf;
   logic [7:0]                lvl;
   logic [2:0]                tsel = 3'h2;
   logic [7:0]                mq[$];
   logic [7:0]                en[4] = '{8'hFF, 8'h40, 8'h10, 8'hAF};
   logic [3:0]                pv[6] = '{4'h0, 4'h1, 4'h3, 4'h4, 4'h5, 4'hF};
   sfic_pkg::sfic_sample_t    smp = '0;
   sfic_pkg::sfic_threshold_t thr = '0;
   sfic_pkg::sfic_entry_t     ent = '0;
   sfic_pkg::sfic_mux_cmd_t   code;
   int                        fail_count = 0, cmp_count = 0, cyc = 0, n0, n_st = 0, n_sy = 0, n_sp = 0;
   always #50 sys_clk = ~sys_clk;
   assign sda = ~(host_oe | sda_oe);
   sfic_top i_sfic_top (.sys_clk(sys_clk), .rst_n(rst_n), .scl_in(scl), .sda_in(sda),
      .sda_out(sda_out), .sda_oe(sda_oe), .measurement_enable(meas), .mux_command_done(mdone),
      .flicker_status(flick), .spectral_sample(smp), .spectral_threshold(thr),
      .threshold_channel_select(tsel), .buffer_entry(ent), .mux_command_start(start_o),
      .mux_command_code(code), .system_interrupt(sysint), .spectral_interrupt(spint),
      .buffer_data_interrupt(birq), .buffer_overflow(ovf), .buffer_level_count(lvl));
   sfic_i2c_host i_sfic_i2c_host (.scl(scl), .host_oe(host_oe), .sda(sda));
   always @(posedge sys_clk) begin
      cyc++;
      n_st += int'(start_o === 1'b1);
      n_sy += int'(sysint === 1'b1);
      n_sp += int'(spint === 1'b1);
      if (cyc == 60000) begin
         fail_count++;
         close_out;
      end
   end
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      cmp_count++;
      if (got !== exp) begin
         $display("CHECK FAILED at %0t got %h exp %h", $time, got, exp);
         fail_count++;
      end
   endtask : chk
   task automatic close_out;
      $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : close_out
   task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
      i_sfic_i2c_host.rd(a, 1);
      chk({8'h00, i_sfic_i2c_host.rq.pop_front()}, {8'h00, e});
   endtask : rdchk
   task automatic drain(input logic [7:0] a, input int n);
      logic [7:0] e;
      i_sfic_i2c_host.rd(a, n);
      repeat (n) begin
         e = (mq.size() > 0) ? mq.pop_front() : 8'h00;
         chk({8'h00, i_sfic_i2c_host.rq.pop_front()}, {8'h00, e});
      end
      chk({8'h00, lvl}, 16'(mq.size() / 2));
      chk(16'(birq), 16'(mq.size() > 0));
   endtask : drain
   task automatic push(input logic [15:0] d);
      @(negedge sys_clk);
      ent = '{valid: 1'b1, data: d};
      @(negedge sys_clk);
      ent.valid = 1'b0;
      if (mq.size() < 256) mq = {mq, d[7:0], d[15:8]};
   endtask : push
   task automatic sample(input logic [2:0] ch, input logic [15:0] v, input int exp);
      n0 = n_sp;
      @(negedge sys_clk);
      smp = '{valid: 1'b1, channel: ch, value: v};
      @(negedge sys_clk);
      smp.valid = 1'b0;
      repeat (3) @(negedge sys_clk);
      chk(16'(n_sp - n0), 16'(exp));
   endtask : sample
   function automatic int need(input logic [3:0] p);
      return (p == 0) ? 1 : (p < 4) ? int'(p) : (p == 4) ? 5 : 5 * (int'(p) - 3);
   endfunction : need
   initial begin
      repeat (12) @(negedge sys_clk);
      rst_n = 1'b1;
      repeat (3) @(negedge sys_clk);
      chk(16'(code), 16'h0002);
      rdchk(8'hAF, 8'h10);
      rdchk(8'hB2, 8'h00);
      rdchk(8'hBD, 8'h00);
      $display("test reset done");
      for (int c = 0; c < 4; c++) begin
         i_sfic_i2c_host.wr(8'hAF, 8'hE7 | 8'(c << 3));
         rdchk(8'hAF, 8'(c << 3));
         n0 = n_st;
         @(negedge sys_clk);
         meas = 1'b1;
         repeat (4) @(negedge sys_clk);
         meas = 1'b0;
         chk(16'(n_st - n0), 16'(c != 3));
         if (c != 3) chk(16'(code), 16'(c));
      end
      $display("test mux done");
      foreach (en[i]) begin
         i_sfic_i2c_host.wr(8'hB2, en[i]);
         rdchk(8'hB2, en[i] & 8'h50);
         n0 = n_sy;
         @(negedge sys_clk);
         flick = ~flick;
         repeat (4) @(negedge sys_clk);
         chk(16'(n_sy - n0), 16'(en[i][6]));
         n0 = n_sy;
         mdone = 1'b1;
         @(negedge sys_clk);
         mdone = 1'b0;
         repeat (4) @(negedge sys_clk);
         chk(16'(n_sy - n0), 16'(en[i][4]));
      end
      $display("test sysint done");
      thr = '{low: 16'h0100, high: 16'h0200};
      foreach (pv[j]) begin
         i_sfic_i2c_host.wr(8'hBD, 8'hF0 | 8'(pv[j]));
         rdchk(8'hBD, 8'(pv[j]));
         for (int r = 0; r < 2; r++) begin
            tsel = r ? 3'h5 : 3'h2;
            sample(tsel, 16'h0100 + 16'(r * 256), int'(pv[j] == 0));
            for (int i = 1; i <= need(pv[j]); i++) begin
               sample(3'h7 - tsel, 16'hFFFF, 0);
               sample(tsel, i[0] ? 16'h0050 : 16'h0201, int'(i == need(pv[j])));
            end
         end
      end
      $display("test persistence done");
      for (int i = 0; i < 3; i++) push(16'hA1B0 + 16'(i));
      drain(8'hFE, 4);
      rdchk(8'hFE, mq[0]);
      chk({8'h00, lvl}, 16'h0001);
      void'(mq.pop_front());
      drain(8'hFF, 1);
      drain(8'hFE, 2);
      for (int i = 0; i < 129; i++) push(16'h5A00 ^ 16'(i * 3));
      chk(16'(ovf), 16'h0001);
      rdchk(8'hFD, 8'h80);
      chk(16'(ovf), 16'h0000);
      drain(8'hFE, 256);
      chk(16'(i_sfic_i2c_host.nack_count), 16'h0000);
      chk(16'(sda_out), 16'h0000);
      $display("test buffer done");
      close_out;
   end
endmodule : sfic_top_test
`default_nettype wire
